// *** rtl/pin_sync.v ***
// three-stage synchroniser with agreement filter for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire ref_clk, // system clock
  input wire sys_rst, // synchronous reset, active high
  input wire [3:0] pin_in, // raw asynchronous levels
  input wire [3:0] rst_val, // level shown after reset, must be a constant at the instance
  output reg [3:0] pin_out // filtered levels
);
  reg [3:0] stg1_r;
  reg [3:0] stg2_r;
  reg [3:0] stg3_r;

  // stage one feeds stage two only; the filter looks at stages two and three
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      stg1_r <= rst_val;
      stg2_r <= rst_val;
      stg3_r <= rst_val;
      pin_out <= rst_val;
    end
    else
    begin
      stg1_r <= pin_in;
      stg2_r <= stg1_r;
      stg3_r <= stg2_r;
      pin_out <= (stg2_r & stg3_r) | (pin_out & (stg2_r ^ stg3_r));
    end
  end
endmodule
`default_nettype wire

// *** rtl/rtc_map.v ***
// two-wire slave with clock/calendar register file and general-purpose memory
//
// Overview of operation
// R1: registers and memory share one slave address
// R2: out-of-range address gets no acknowledge
// R3: register block decoded at 0x00-0x1f
// R4: 64-byte memory decoded at 0x20-0x5f
// R5: contents held while on backup supply
// R6: alarm hour-format bit mirrors timekeeping hour
// R7: second alarm polarity mirrors first alarm
// R8: crystal runs only while start bit set
// R9: crystal or external clock timebase selectable
// R10: external clock path needs select bit
// R11: last address bit: one read, zero write
// R12: host never writes reserved locations; the bench does, and the map ignores those writes
// R13: pointer advances after every data byte
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map_regs.vh"
module rtc_map (
  input wire ref_clk, // 40 MHz system clock
  input wire sys_rst, // synchronous reset, active high
  input wire scl_i, // serial clock pin level
  input wire sda_i, // serial data pin level
  output wire sda_o, // serial data drive value, always low
  output reg sda_oe, // serial data pull-low enable
  input wire backup_mode, // running from backup supply, serial port off
  input wire osc_running, // timebase activity seen by the oscillator monitor
  output reg oscillator_start, // start bit of the seconds register
  output reg external_clock_select, // external clock select of the control register
  output reg crystal_osc_en, // enable for the crystal amplifier
  output reg ext_clk_path_en // enable for the external clock input path
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_REG = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_ACK = 3'd4;
  localparam ST_RDATA = 3'd5;
  localparam ST_RACK = 3'd6;

  reg [7:0] regs_r [0:`REG_WORDS-1];
  reg [7:0] sram_r [0:`SRAM_WORDS-1];

  reg [2:0] state_r;
  reg [2:0] after_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] tx_r;
  reg [6:0] ptr_r;
  reg ack_r;
  reg ack_drv_r;
  reg master_ack_r;
  reg scl_q_r;
  reg sda_q_r;

  wire [3:0] sync_out;
  wire scl_s;
  wire sda_s;
  wire backup_s;
  wire osc_run_s;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire [7:0] rx_byte;
  wire [6:0] sram_off = ptr_r - `SRAM_FIRST;
  integer i;

  pin_sync u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in({osc_running, backup_mode, sda_i, scl_i}),
    .rst_val(4'h3),
    .pin_out(sync_out)
  );

  assign scl_s = sync_out[0];
  assign sda_s = sync_out[1];
  assign backup_s = sync_out[2];
  assign osc_run_s = sync_out[3];
  assign sda_o = 1'b0;

  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign start_seen = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_seen = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign rx_byte = {shift_r[6:0], sda_s};

  // writable bits per register; reserved and unimplemented locations take nothing
  function [7:0] wmask;
    input [4:0] idx;
    begin
      case (idx)
        `OFS_TIME_SECONDS: wmask = 8'hff;
        `OFS_TIME_MINUTES: wmask = 8'h7f;
        `OFS_TIME_HOURS: wmask = 8'h7f;
        `OFS_TIME_WEEKDAY_STATUS: wmask = 8'h1f;
        `OFS_TIME_DATE: wmask = 8'h3f;
        `OFS_TIME_MONTH: wmask = 8'h3f;
        `OFS_TIME_YEAR: wmask = 8'hff;
        `OFS_OUTPUT_AND_OSC_CONTROL: wmask = 8'hff;
        `OFS_OSCILLATOR_TRIM: wmask = 8'hff;
        `OFS_ALARM0_SECONDS: wmask = 8'h7f;
        `OFS_ALARM0_MINUTES: wmask = 8'h7f;
        `OFS_ALARM0_HOURS: wmask = 8'h3f; // R6
        `OFS_ALARM0_WEEKDAY_MASK: wmask = 8'hff;
        `OFS_ALARM0_DATE: wmask = 8'h3f;
        `OFS_ALARM0_MONTH: wmask = 8'h1f;
        `OFS_ALARM1_SECONDS: wmask = 8'h7f;
        `OFS_ALARM1_MINUTES: wmask = 8'h7f;
        `OFS_ALARM1_HOURS: wmask = 8'h3f; // R6
        `OFS_ALARM1_WEEKDAY_MASK: wmask = 8'h7f; // R7
        `OFS_ALARM1_DATE: wmask = 8'h3f;
        `OFS_ALARM1_MONTH: wmask = 8'h1f;
        `OFS_POWER_DOWN_MINUTES: wmask = 8'h7f;
        `OFS_POWER_DOWN_HOURS: wmask = 8'h7f;
        `OFS_POWER_DOWN_DATE: wmask = 8'h3f;
        `OFS_POWER_DOWN_WEEKDAY_MONTH: wmask = 8'hff;
        `OFS_POWER_UP_MINUTES: wmask = 8'h7f;
        `OFS_POWER_UP_HOURS: wmask = 8'h7f;
        `OFS_POWER_UP_DATE: wmask = 8'h3f;
        default: wmask = 8'h00; // R12
      endcase
    end
  endfunction

  // pointer wraps inside its own block so a burst never leaves the map
  function [6:0] next_ptr;
    input [6:0] p;
    begin
      if (p == `REG_LAST)
        next_ptr = `REG_FIRST;
      else if (p == `SRAM_LAST)
        next_ptr = `SRAM_FIRST;
      else
        next_ptr = p + 7'd1;
    end
  endfunction

  function in_range;
    input [7:0] a;
    begin
      in_range = (a <= {1'b0, `SRAM_LAST}); // R2
    end
  endfunction

  // read view with the mirrored and status bits folded in
  reg [7:0] rd_data;
  always @*
  begin
    rd_data = 8'h00;
    if (ptr_r <= `REG_LAST) // R3
    begin
      rd_data = regs_r[ptr_r[4:0]] & wmask(ptr_r[4:0]);
      if (ptr_r[4:0] == `OFS_ALARM0_HOURS || ptr_r[4:0] == `OFS_ALARM1_HOURS)
        rd_data[`BIT_HOUR_FORMAT] = regs_r[`OFS_TIME_HOURS][`BIT_HOUR_FORMAT]; // R6
      else if (ptr_r[4:0] == `OFS_ALARM1_WEEKDAY_MASK)
        rd_data[`BIT_ALARM_OUTPUT_POLARITY] =
          regs_r[`OFS_ALARM0_WEEKDAY_MASK][`BIT_ALARM_OUTPUT_POLARITY]; // R7
      else if (ptr_r[4:0] == `OFS_TIME_WEEKDAY_STATUS)
        rd_data[`BIT_OSC_RUNNING] = osc_run_s;
    end
    else
    begin
      rd_data = sram_r[sram_off[5:0]]; // R4
    end
  end

  // edge history of the filtered pins
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  // register file: cleared by sys_rst only, held across backup operation
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (i = 0; i < `REG_WORDS; i = i + 1)
        regs_r[i] <= `RST_REG;
    end
    else if (!backup_s && state_r == ST_WDATA && scl_rise && bit_cnt_r == 3'd7
             && ptr_r <= `REG_LAST) // R5
    begin
      regs_r[ptr_r[4:0]] <= (regs_r[ptr_r[4:0]] & ~wmask(ptr_r[4:0]))
                            | (rx_byte & wmask(ptr_r[4:0])); // R3
    end
  end

  // memory carries no reset: battery keeps it, so power-up must not wipe it
  always @(posedge ref_clk)
  begin
    if (!sys_rst && !backup_s && state_r == ST_WDATA && scl_rise && bit_cnt_r == 3'd7
        && ptr_r >= `SRAM_FIRST) // R5
      sram_r[sram_off[5:0]] <= rx_byte; // R4
  end

  // serial protocol engine
  always @(posedge ref_clk)
  begin
    if (sys_rst || backup_s)
    begin
      state_r <= ST_IDLE;
      after_r <= ST_IDLE;
      bit_cnt_r <= 3'd0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 7'h00;
      ack_r <= 1'b0;
      ack_drv_r <= 1'b0;
      master_ack_r <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (start_seen)
    begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 3'd0;
      ack_drv_r <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (stop_seen)
    begin
      state_r <= ST_IDLE;
      ack_drv_r <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_ADDR, ST_REG, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7)
            begin
              state_r <= ST_ACK;
              ack_drv_r <= 1'b0;
              if (state_r == ST_ADDR)
              begin
                ack_r <= (rx_byte[7:1] == `SLAVE_ADDR); // R1
                after_r <= (rx_byte[0] == `RW_READ) ? ST_RDATA : ST_REG; // R11
              end
              else if (state_r == ST_REG)
              begin
                ack_r <= in_range(rx_byte); // R2
                ptr_r <= in_range(rx_byte) ? rx_byte[6:0] : ptr_r; // R2
                after_r <= ST_WDATA;
              end
              else
              begin
                ack_r <= 1'b1;
                ptr_r <= next_ptr(ptr_r); // R13
                after_r <= ST_WDATA;
              end
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall && !ack_drv_r)
          begin
            sda_oe <= ack_r;
            ack_drv_r <= 1'b1;
          end
          else if (scl_fall)
          begin
            ack_drv_r <= 1'b0;
            bit_cnt_r <= 3'd0;
            if (!ack_r)
            begin
              sda_oe <= 1'b0;
              state_r <= ST_IDLE; // R2
            end
            else if (after_r == ST_RDATA)
            begin
              tx_r <= rd_data;
              sda_oe <= ~rd_data[7];
              state_r <= ST_RDATA;
            end
            else
            begin
              sda_oe <= 1'b0;
              state_r <= after_r;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7)
            begin
              sda_oe <= 1'b0;
              state_r <= ST_RACK;
            end
            else
            begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe <= ~tx_r[6];
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            master_ack_r <= ~sda_s;
            ptr_r <= next_ptr(ptr_r); // R13
          end
          else if (scl_fall)
          begin
            bit_cnt_r <= 3'd0;
            if (master_ack_r)
            begin
              tx_r <= rd_data;
              sda_oe <= ~rd_data[7];
              state_r <= ST_RDATA;
            end
            else
            begin
              sda_oe <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
        end
        default:
        begin
          sda_oe <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // timebase source selection from the configuration bits
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      oscillator_start <= 1'b0;
      external_clock_select <= 1'b0;
      crystal_osc_en <= 1'b0;
      ext_clk_path_en <= 1'b0;
    end
    else
    begin
      oscillator_start <= regs_r[`OFS_TIME_SECONDS][`BIT_OSCILLATOR_START];
      external_clock_select <= regs_r[`OFS_OUTPUT_AND_OSC_CONTROL][`BIT_EXTERNAL_CLOCK_SELECT];
      // external select wins so the amplifier never fights an applied clock
      crystal_osc_en <= regs_r[`OFS_TIME_SECONDS][`BIT_OSCILLATOR_START]
                        & ~regs_r[`OFS_OUTPUT_AND_OSC_CONTROL][`BIT_EXTERNAL_CLOCK_SELECT]; // R8
      ext_clk_path_en <= regs_r[`OFS_OUTPUT_AND_OSC_CONTROL][`BIT_EXTERNAL_CLOCK_SELECT]; // R9 R10
    end
  end
endmodule
`default_nettype wire

// *** rtl/rtc_map_regs.vh ***
// address map, slave address and field constants of the clock/calendar register map
`ifndef RTC_MAP_REGS_VH
`define RTC_MAP_REGS_VH

// bus addressing
`define SLAVE_ADDR 7'h6f
`define RW_READ 1'b1

// address space
`define REG_FIRST 7'h00
`define REG_LAST 7'h1f
`define SRAM_FIRST 7'h20
`define SRAM_LAST 7'h5f
`define SRAM_WORDS 64
`define REG_WORDS 32

// register offsets
`define OFS_TIME_SECONDS 5'h00
`define OFS_TIME_MINUTES 5'h01
`define OFS_TIME_HOURS 5'h02
`define OFS_TIME_WEEKDAY_STATUS 5'h03
`define OFS_TIME_DATE 5'h04
`define OFS_TIME_MONTH 5'h05
`define OFS_TIME_YEAR 5'h06
`define OFS_OUTPUT_AND_OSC_CONTROL 5'h07
`define OFS_OSCILLATOR_TRIM 5'h08
`define OFS_RESERVED_GAP_A 5'h09
`define OFS_ALARM0_SECONDS 5'h0a
`define OFS_ALARM0_MINUTES 5'h0b
`define OFS_ALARM0_HOURS 5'h0c
`define OFS_ALARM0_WEEKDAY_MASK 5'h0d
`define OFS_ALARM0_DATE 5'h0e
`define OFS_ALARM0_MONTH 5'h0f
`define OFS_RESERVED_GAP_B 5'h10
`define OFS_ALARM1_SECONDS 5'h11
`define OFS_ALARM1_MINUTES 5'h12
`define OFS_ALARM1_HOURS 5'h13
`define OFS_ALARM1_WEEKDAY_MASK 5'h14
`define OFS_ALARM1_DATE 5'h15
`define OFS_ALARM1_MONTH 5'h16
`define OFS_RESERVED_GAP_C 5'h17
`define OFS_POWER_DOWN_MINUTES 5'h18
`define OFS_POWER_DOWN_HOURS 5'h19
`define OFS_POWER_DOWN_DATE 5'h1a
`define OFS_POWER_DOWN_WEEKDAY_MONTH 5'h1b
`define OFS_POWER_UP_MINUTES 5'h1c
`define OFS_POWER_UP_HOURS 5'h1d
`define OFS_POWER_UP_DATE 5'h1e

// field positions
`define BIT_OSCILLATOR_START 7
`define BIT_HOUR_FORMAT 6
`define BIT_OSC_RUNNING 5
`define BIT_ALARM_OUTPUT_POLARITY 7
`define BIT_EXTERNAL_CLOCK_SELECT 3

// reset values
`define RST_REG 8'h00

`endif

// *** tb/i2c_host_model.sv ***
// two-wire bus host model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic ref_clk, // clock
  input wire logic sda_oe, // device pull-low
  input wire logic sda_o, // device drive value
  output logic scl, // serial clock wire
  output wire logic sda // serial data wire
);
  logic drv;
  // pulled-up wire: low if either side pulls
  assign sda = drv & (sda_oe ? sda_o : 1'b1);
  initial
  begin
    scl = 1'b1;
    drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // data moves 5 cycles after the fall, so the filtered clock is seen low first
  task automatic bit_cycle(input logic b, output logic r);
    drv <= b;
    hold(10);
    scl <= 1'b1;
    hold(10);
    r = sda;
    scl <= 1'b0;
    hold(5);
  endtask
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
    output logic a_out);
    for (int i = 7; i >= 0; i--)
      bit_cycle(d[i], q[i]);
    bit_cycle(a_in, a_out);
  endtask
  task automatic start_cond();
    drv <= 1'b1;
    hold(10);
    scl <= 1'b1;
    hold(10);
    drv <= 1'b0;
    hold(10);
    scl <= 1'b0;
    hold(5);
  endtask
  task automatic stop_cond();
    drv <= 1'b0;
    hold(10);
    scl <= 1'b1;
    hold(10);
    drv <= 1'b1;
    hold(10);
  endtask
endmodule
`default_nettype wire

// *** tb/rtc_calendar_register_map_test.sv ***
// self-checking bench for the register map over the two-wire port
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_register_map_test;
  logic ref_clk, sys_rst, backup_mode, osc_running, scl, sda, sda_oe, sda_o;
  logic oscillator_start, external_clock_select, crystal_osc_en, ext_clk_path_en;
  logic [7:0] rq[$];
  logic [7:0] rsv[3] = '{8'h09, 8'h10, 8'h17};
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  rtc_map dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .backup_mode(backup_mode), .osc_running(osc_running),
    .oscillator_start(oscillator_start), .external_clock_select(external_clock_select),
    .crystal_osc_en(crystal_osc_en), .ext_clk_path_en(ext_clk_path_en));
  i2c_host_model m (.ref_clk(ref_clk), .sda_oe(sda_oe), .sda_o(sda_o), .scl(scl), .sda(sda));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic results();
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: byte %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: bit %b want %b", $time, got, exp);
    end
  endtask
  task automatic head(input logic [7:0] p);
    logic [7:0] q;
    logic a;
    m.start_cond();
    m.xfer(8'hde, 1'b1, q, a);
    chk1(a, 1'b0);
    m.xfer(p, 1'b1, q, a);
    chk1(a, 1'b0);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    logic [7:0] q;
    logic a;
    head(p);
    foreach (d[i])
    begin
      m.xfer(d[i], 1'b1, q, a);
      chk1(a, 1'b0);
    end
    m.stop_cond();
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] q;
    logic a;
    rq.delete();
    head(p);
    m.start_cond();
    m.xfer(8'hdf, 1'b1, q, a);
    chk1(a, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      m.xfer(8'hff, i == n - 1, q, a);
      rq.push_back(q);
    end
    m.stop_cond();
  endtask
  // refused access: expected acknowledge levels of control and pointer bytes
  task automatic probe(input logic [7:0] c, input logic [7:0] p, input logic e1, input logic e2);
    logic [7:0] q;
    logic a;
    m.start_cond();
    m.xfer(c, 1'b1, q, a);
    chk1(a, e1);
    m.xfer(p, 1'b1, q, a);
    chk1(a, e2);
    m.stop_cond();
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      err_count++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    backup_mode = 1'b0;
    osc_running = 1'b0;
    m.hold(4);
    sys_rst <= 1'b0;
    m.hold(10);
    rd(8'h00, 9);
    foreach (rq[i]) chk8(rq[i], 8'h00);
    osc_running <= 1'b1;
    wr(8'h1e, '{8'h25, 8'h77, 8'h12});
    rd(8'h1e, 6);
    chk8(rq[0], 8'h25);
    chk8(rq[1], 8'h00);
    chk8(rq[2], 8'h12);
    chk8(rq[5], 8'h20);
    foreach (rsv[i])
    begin
      wr(rsv[i], '{8'hff});
      rd(rsv[i], 1);
      chk8(rq[0], 8'h00);
    end
    probe(8'hde, 8'h60, 1'b0, 1'b1);
    probe(8'hdc, 8'h00, 1'b1, 1'b1);
    wr(8'h5f, '{8'h3c, 8'hc3});
    rd(8'h5f, 2);
    chk8(rq[0], 8'h3c);
    chk8(rq[1], 8'hc3);
    wr(8'h02, '{8'h40});
    wr(8'h0c, '{8'h00});
    rd(8'h0c, 1);
    chk8(rq[0], 8'h40);
    rd(8'h13, 1);
    chk8(rq[0], 8'h40);
    wr(8'h0d, '{8'h80});
    wr(8'h14, '{8'h00});
    rd(8'h14, 1);
    chk8(rq[0], 8'h80);
    wr(8'h00, '{8'h80});
    chk1(oscillator_start, 1'b1);
    chk1(crystal_osc_en, 1'b1);
    chk1(ext_clk_path_en, 1'b0);
    wr(8'h07, '{8'h08});
    chk1(external_clock_select, 1'b1);
    chk1(ext_clk_path_en, 1'b1);
    chk1(crystal_osc_en, 1'b0);
    backup_mode <= 1'b1;
    m.hold(10);
    probe(8'hde, 8'h20, 1'b1, 1'b1);
    backup_mode <= 1'b0;
    m.hold(10);
    rd(8'h20, 1);
    chk8(rq[0], 8'hc3);
    sys_rst <= 1'b1;
    m.hold(4);
    sys_rst <= 1'b0;
    m.hold(10);
    chk1(oscillator_start, 1'b0);
    rd(8'h20, 1);
    chk8(rq[0], 8'hc3);
    results();
  end
endmodule
`default_nettype wire

// *** tb/rtc_map_assertions.sv ***
// concurrent checks on the register map port behaviour
`timescale 1ns/1ps
`default_nettype none
module rtc_map_assertions (
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic scl_i, // serial clock
  input wire logic sda_o, // drive value
  input wire logic sda_oe, // pull-low enable
  input wire logic backup_mode, // backup supply
  input wire logic oscillator_start, // start bit
  input wire logic external_clock_select, // select bit
  input wire logic crystal_osc_en, // crystal enable
  input wire logic ext_clk_path_en // external path enable
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence backup_held;
    backup_mode [*6];
  endsequence
  sequence drive_run;
    sda_oe [*8];
  endsequence
  chk_crystal_gate: assert property (crystal_osc_en == (oscillator_start && !external_clock_select))
    else $error("crystal enable disagrees with start and select");
  chk_ext_path: assert property (ext_clk_path_en == external_clock_select)
    else $error("external path enable disagrees with select");
  chk_reset_clear: assert property ($fell(sys_rst) |-> !(sda_oe || oscillator_start ||
    external_clock_select || crystal_osc_en || ext_clk_path_en))
    else $error("outputs not cleared by reset");
  chk_backup_idle: assert property (backup_held |-> !sda_oe)
    else $error("serial port drives while on backup");
  chk_backup_frozen: assert property (backup_held |=> $stable(oscillator_start) &&
    $stable(external_clock_select))
    else $error("control changed while on backup");
  chk_turn_on_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data drive changed while clock high");
  chk_hold_high: assert property ($rose(scl_i) |=> $stable(sda_oe) [*6])
    else $error("data drive not held through clock high");
  chk_ack_length: assert property ($rose(sda_oe) |-> drive_run)
    else $error("data drive pulse too short");
  chk_drive_low: assert property (sda_oe |-> !sda_o)
    else $error("drive value not low");
endmodule
bind rtc_map rtc_map_assertions chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .backup_mode(backup_mode),
  .oscillator_start(oscillator_start), .external_clock_select(external_clock_select),
  .crystal_osc_en(crystal_osc_en), .ext_clk_path_en(ext_clk_path_en));
`default_nettype wire
